/* File: bench/adc_cfg_sva.sv */
// checker: port-level properties of the config register bank
`default_nettype none
module adc_cfg_sva
    import adc_cfg_pkg::*;
(
    // clock, reset and register bus
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    // error, data and pin side
    input wire logic        i_crc_error,
    input wire logic        i_force_analog,
    input wire logic        i_data_rd,
    input wire logic [11:0] o_data_word,
    input wire logic        o_conv_start,
    input wire logic [7:0]  o_avg_samples,
    input wire logic [7:0]  o_pin_gpio,
    input wire logic [7:0]  o_pin_output,
    input wire logic        o_crc_error_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========
    // properties
    a_unmapped_zero:
        assert property (i_reg_rd && i_reg_addr == 8'h06 |=> !o_reg_rdata)
        else $error("unmapped read not zero");
    a_flag_sets:
        assert property (i_crc_error |=> o_crc_error_flag)
        else $error("error flag not set");
    a_flag_sticky:
        assert property (o_crc_error_flag && !(i_reg_wr && i_reg_wdata[1]
            && i_reg_addr == ADDR_STATUS) |=> o_crc_error_flag)
        else $error("error flag dropped");
    a_write_blocked:
        assert property ($past(o_crc_error_flag) && o_crc_error_flag
            && i_reg_wr && i_reg_addr == ADDR_CHAN_FUNC && !i_force_analog
            |=> $stable(o_pin_gpio))
        else $error("write passed while flag set");
    a_avg_power:
        assert property ($onehot(o_avg_samples))
        else $error("sample count not a power of two");
    a_force_zero:
        assert property (i_force_analog ##1 i_force_analog
            |-> o_pin_gpio == 8'h00 && o_pin_output == 8'h00)
        else $error("pins not forced analog");
    a_output_gpio:
        assert property ((o_pin_output & ~o_pin_gpio) == 8'h00)
        else $error("output on analog channel");
    a_start_pulse:
        assert property (o_conv_start |=> !o_conv_start)
        else $error("start longer than a cycle");
    a_data_holds:
        assert property (!i_data_rd |=> $stable(o_data_word))
        else $error("data word changed without read");
    a_rdata_holds:
        assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
    // main scenarios reached
    c_start: cover property (o_conv_start);
    c_blocked: cover property (o_crc_error_flag && i_reg_wr);
    c_fixed: cover property (i_data_rd ##1 o_data_word == FIXED_CODE);
endmodule
bind adc_mode_config_regs adc_cfg_sva u_sva (.i_clk, .i_rst, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_crc_error,
    .i_force_analog, .i_data_rd, .o_data_word, .o_conv_start,
    .o_avg_samples, .o_pin_gpio, .o_pin_output, .o_crc_error_flag);
`default_nettype wire

/* File: bench/adc_mode_config_regs_tb_top.sv */
// testbench: config register bank driven by a host model
`default_nettype none
module adc_mode_config_regs_tb_top;
    import adc_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // signals named as the ports they feed
    logic        i_clk = 1'b0, i_rst = 1'b1, i_reg_wr, i_reg_rd;
    logic        i_crc_error = 1'b0, i_force_analog = 1'b0;
    logic        i_host_conv_req = 1'b0, i_data_rd = 1'b0;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_avg_samples;
    logic [7:0]  o_pin_gpio, o_pin_output;
    logic [11:0] i_conv_result = 12'h000, o_data_word;
    logic [3:0]  i_conv_channel = 4'h0, i_conv_flags = 4'h0, o_data_tag;
    logic        o_data_tag_valid, o_conv_start, o_osc_low_power;
    logic        o_crc_error_flag;
    int          miscompares = 0, total_checks = 0, cycles = 0, starts = 0;
    logic [7:0]  regs [5] = '{ADDR_DATA_FORMAT, ADDR_AVERAGING,
                              ADDR_OPMODE, ADDR_CHAN_FUNC, ADDR_DIRECTION};
    adc_mode_config_regs dut (.*);
    cfg_host_model u_host (.i_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata));
    always #2.5 i_clk = ~i_clk;
    // start counter and hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        starts += o_conv_start;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    // ==========
    // helpers
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            ADDR_DATA_FORMAT: return MASK_DATA_FORMAT;
            ADDR_AVERAGING:   return MASK_AVERAGING;
            default:          return MASK_FULL;
        endcase
    endfunction
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [11:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, exp);
        logic [7:0] q;
        u_host.read(a, q);
        chk({4'h0, q}, {4'h0, exp});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [1:0] app;
        void'($urandom(92210));
        repeat (3) tick();
        i_rst = 1'b0;
        foreach (regs[k]) chk_reg(regs[k], RESET_VALUE);
        chk_reg(8'h06, 8'h00);
        repeat (4) foreach (regs[k])
        begin
            d = 8'($urandom);
            u_host.write(regs[k], d);
            chk_reg(regs[k], d & mask_of(regs[k]));
        end
        for (int c = 0; c < 8; c++)
        begin
            u_host.write(ADDR_AVERAGING, 8'(c));
            chk({4'h0, o_avg_samples}, 12'(1 << c));
        end
        $display("test registers done");
        for (int m = 0; m < 6; m++)
        begin
            app = 2'(m >> 1);
            u_host.write(ADDR_DATA_FORMAT, {m[0], 1'b0, app, 4'h0});
            {i_conv_result, i_conv_channel, i_conv_flags} = 20'($urandom);
            tick();
            i_data_rd = 1'b1;
            tick();
            i_data_rd = 1'b0;
            chk(o_data_word, m[0] ? FIXED_CODE : i_conv_result);
            chk(o_data_tag, app == 1 ? i_conv_channel :
                app == 2 ? i_conv_flags : 4'h0);
            chk(o_data_tag_valid, app != 0);
        end
        $display("test format done");
        d = 8'($urandom);
        u_host.write(ADDR_CHAN_FUNC, 8'hf0);
        u_host.write(ADDR_DIRECTION, d);
        chk(o_pin_gpio, 8'hf0);
        chk(o_pin_output, 8'hf0 & d);
        i_force_analog = 1'b1;
        repeat (2) tick();
        chk(o_pin_gpio | o_pin_output, 8'h00);
        i_force_analog = 1'b0;
        u_host.write(ADDR_OPMODE, 8'h10);
        chk(o_osc_low_power, 1'b1);
        // let a sequencer left in autonomous wait drop back to idle
        tick();
        i_host_conv_req = 1'b1;
        tick();
        i_host_conv_req = 1'b0;
        chk(o_conv_start, 1'b1);
        u_host.write(ADDR_OPMODE, 8'h21);
        starts = 0;
        repeat (1000) tick();
        chk(starts >= 2 && starts <= 3, 1'b1);
        $display("test pins and modes done");
        for (int e = 0; e < 2; e++)
        begin
            u_host.write(ADDR_OPMODE, e ? 8'ha0 : 8'h20);
            i_crc_error = 1'b1;
            tick();
            i_crc_error = 1'b0;
            chk(o_crc_error_flag, 1'b1);
            u_host.write(ADDR_CHAN_FUNC, 8'h0f);
            chk(o_pin_gpio, e ? 8'h00 : 8'hf0);
            starts = 0;
            repeat (450) tick();
            chk(starts == 0, e);
            u_host.write(ADDR_STATUS, 8'h02);
            chk(o_crc_error_flag, 1'b0);
            chk_reg(ADDR_CHAN_FUNC, 8'hf0);
            chk(o_pin_gpio, 8'hf0);
        end
        $display("test crc error done");
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: bench/cfg_host_model.sv */
// partner: serial host side issuing register writes and reads
`default_nettype none
module cfg_host_model
(
    // clock
    input  wire logic       i_clk,
    // register bus towards the bank
    output var  logic       o_wr,
    output var  logic       o_rd,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata,
    input  wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // raised after an edge, taken at the next, then let go
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge i_clk);
        #1;
        {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_clk);
        #1;
        // released lines must not keep showing the old value
        {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask
    task automatic write(input logic [7:0] a, d);
        access(1'b1, a, d);
    endtask
    // read-back is how a dropped write is noticed
    task automatic read(input logic [7:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00);
        q = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: design/adc_cfg_pkg.sv */
// package: register map, field layout and constants for the config bank
// Operation
// (RULE_01) fixed pattern bit forces data 0xa5a
// (RULE_02) reserved bits always read zero
// (RULE_03) append field: none, channel id, status
// (RULE_04) averaging count is two to the code
// (RULE_05) crc error, continue off: keep running
// (RULE_06) crc error, continue on: force analog, pause
// (RULE_07) manual mode: conversions only on host request
// (RULE_08) autonomous mode: internal machine starts conversions
// (RULE_09) oscillator select: zero fast, one low power
// (RULE_10) divider field sets autonomous sampling rate
// (RULE_11) channel function bit: zero analog, one gpio
// (RULE_12) direction bit: zero input, one output
// (RULE_13) all five registers reset to zero
// (RULE_14) registers decode at 0x2,0x3,0x4,0x5,0x7
// (RULE_15) crc error sticky, write-one clear, blocks writes
// (RULE_16) force analog overrides function and direction
// (RULE_17) reserved bit writes have no effect
// (RULE_18) host reads back to confirm writes
`default_nettype none
package adc_cfg_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS      = 8'h00;
    localparam logic [7:0] ADDR_GENERAL     = 8'h01;
    localparam logic [7:0] ADDR_DATA_FORMAT = 8'h02;
    localparam logic [7:0] ADDR_AVERAGING   = 8'h03;
    localparam logic [7:0] ADDR_OPMODE      = 8'h04;
    localparam logic [7:0] ADDR_CHAN_FUNC   = 8'h05;
    localparam logic [7:0] ADDR_DIRECTION   = 8'h07;
    // ==========================================================
    // writable bit masks, reserved positions are zero
    localparam logic [7:0] MASK_DATA_FORMAT = 8'hb0;
    localparam logic [7:0] MASK_AVERAGING   = 8'h07;
    localparam logic [7:0] MASK_FULL        = 8'hff;
    localparam logic [7:0] RESET_VALUE      = 8'h00;
    // ==========================================================
    // field positions
    localparam int FIXED_PATTERN_BIT  = 7;
    localparam int APPEND_LSB         = 4;
    localparam int CONT_ON_ERR_BIT    = 7;
    localparam int CONVERSION_MODE_LSB      = 5;
    localparam int OSCILLATOR_SELECT_BIT        = 4;
    localparam int CLK_DIV_LSB        = 0;
    localparam int CRC_ERR_BIT        = 1;
    localparam int FORCE_ANALOG_BIT   = 2;
    // ==========================================================
    // encodings and data values
    localparam logic [11:0] FIXED_CODE     = 12'ha5a;
    localparam logic [1:0]  APPEND_NONE    = 2'h0;
    localparam logic [1:0]  APPEND_CHAN_ID = 2'h1;
    localparam logic [1:0]  APPEND_STATUS  = 2'h2;
    localparam logic [1:0]  MODE_MANUAL    = 2'h0;
    localparam logic [1:0]  MODE_AUTO      = 2'h1;
    localparam int          NUM_CHANNELS   = 8;
    // ==========================================================
    // divider base: one tick at the fastest autonomous rate
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          BASE_PERIOD_NS  = 1000;
    localparam logic [15:0] BASE_CYCLES     =
        16'((BASE_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000);

    // ==========================================================
    // register bank contents
    typedef struct packed {
        logic [7:0] data_format_config;
        logic [7:0] averaging_config;
        logic [7:0] operating_mode_config;
        logic [7:0] channel_function_config;
        logic [7:0] digital_direction_config;
        logic       crc_error;
    } cfg_regs_t;

    // register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // sequencing states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_PAUSED
    } seq_state_t;

    // whole module state
    typedef struct packed {
        cfg_regs_t   regs;
        seq_state_t  seq;
        logic [15:0] base_cnt;
        logic [15:0] div_cnt;
        logic [7:0]  rdata;
        logic [11:0] sample;
        logic [3:0]  tag;
        logic        start;
    } state_t;
endpackage
`default_nettype wire

/* File: design/adc_mode_config_regs.sv */
// module: configuration register bank and conversion start control
`default_nettype none
module adc_mode_config_regs
    import adc_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // register access from the serial interface core
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output var  logic [7:0]  o_reg_rdata,
    // crc checker and force-analog control
    input  wire logic        i_crc_error,
    input  wire logic        i_force_analog,
    // conversion interface
    input  wire logic        i_host_conv_req,
    input  wire logic [11:0] i_conv_result,
    input  wire logic [3:0]  i_conv_channel,
    input  wire logic [3:0]  i_conv_flags,
    input  wire logic        i_data_rd,
    output var  logic [11:0] o_data_word,
    output var  logic [3:0]  o_data_tag,
    output var  logic        o_data_tag_valid,
    output var  logic        o_conv_start,
    output var  logic [7:0]  o_avg_samples,
    output var  logic        o_osc_low_power,
    // effective pin configuration and crc error flag
    output var  logic [7:0]  o_pin_gpio,
    output var  logic [7:0]  o_pin_output,
    output var  logic        o_crc_error_flag
);

    // ==========================================================
    // state
    state_t q;        // registered state
    state_t next_q;   // next state

    // decoded fields
    logic       write_ok;
    logic       force_all;
    logic       seq_hold;
    logic [1:0] conversion_mode;
    logic [3:0] clk_div;
    logic [1:0] append_sel;

    // ==========================================================
    // field decode
    always_comb
    begin
        conversion_mode  = q.regs.operating_mode_config[CONVERSION_MODE_LSB +: 2];
        clk_div    = q.regs.operating_mode_config[CLK_DIV_LSB +: 4];
        append_sel = q.regs.data_format_config[APPEND_LSB +: 2];
        // writes blocked while crc error pending, except 0x0/0x1
        write_ok = i_reg_wr && (!q.regs.crc_error ||
                   i_reg_addr == ADDR_STATUS ||
                   i_reg_addr == ADDR_GENERAL);              // RULE_15
        // error forces analog only when continue bit is set
        seq_hold = q.regs.crc_error &&
                   q.regs.operating_mode_config[CONT_ON_ERR_BIT]; // RULE_06
        force_all = i_force_analog || seq_hold;              // RULE_16
    end

    // ==========================================================
    // next state
    always_comb
    begin
        next_q       = q;
        next_q.start = 1'b0;

        // register writes, masked so reserved bits stay zero
        if (write_ok)
        begin
            unique case (i_reg_addr)                         // RULE_14
                ADDR_STATUS:
                begin
                    // write one clears, handled with set below
                end
                ADDR_DATA_FORMAT:
                    next_q.regs.data_format_config =
                        i_reg_wdata & MASK_DATA_FORMAT;      // RULE_17
                ADDR_AVERAGING:
                    next_q.regs.averaging_config =
                        i_reg_wdata & MASK_AVERAGING;        // RULE_02
                ADDR_OPMODE:
                    next_q.regs.operating_mode_config =
                        i_reg_wdata & MASK_FULL;
                ADDR_CHAN_FUNC:
                    next_q.regs.channel_function_config =
                        i_reg_wdata;                         // RULE_11
                ADDR_DIRECTION:
                    next_q.regs.digital_direction_config =
                        i_reg_wdata;                         // RULE_12
                default:
                begin
                    // unmapped or out of this bank: ignored
                end
            endcase
        end

        // sticky crc flag, a new error wins over the clear
        if (i_reg_wr && i_reg_addr == ADDR_STATUS &&
            i_reg_wdata[CRC_ERR_BIT])
            next_q.regs.crc_error = 1'b0;                    // RULE_15
        if (i_crc_error)
            next_q.regs.crc_error = 1'b1;                    // RULE_15

        // read data, reserved bits already zero in storage
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                ADDR_STATUS:
                    next_q.rdata = {6'h00, q.regs.crc_error, 1'b0};
                ADDR_DATA_FORMAT:
                    next_q.rdata = q.regs.data_format_config;
                ADDR_AVERAGING:
                    next_q.rdata = q.regs.averaging_config;  // RULE_02
                ADDR_OPMODE:
                    next_q.rdata = q.regs.operating_mode_config;
                ADDR_CHAN_FUNC:
                    next_q.rdata = q.regs.channel_function_config;
                ADDR_DIRECTION:
                    next_q.rdata = q.regs.digital_direction_config;
                default:
                    next_q.rdata = 8'h00;
            endcase
        end

        // base tick divider, free running in any mode
        if (q.base_cnt == BASE_CYCLES - 16'h0001)
            next_q.base_cnt = 16'h0000;
        else
            next_q.base_cnt = q.base_cnt + 16'h0001;

        // conversion start sequencing
        unique case (q.seq)
            SEQ_IDLE:
            begin
                if (seq_hold)
                    next_q.seq = SEQ_PAUSED;                 // RULE_06
                else if (conversion_mode == MODE_AUTO)
                begin
                    next_q.seq     = SEQ_WAIT;               // RULE_08
                    next_q.div_cnt = 16'h0000;
                end
                else if (conversion_mode == MODE_MANUAL &&
                         i_host_conv_req)
                    next_q.start = 1'b1;                     // RULE_07
            end
            SEQ_WAIT:
            begin
                if (seq_hold)
                    next_q.seq = SEQ_PAUSED;                 // RULE_06
                else if (conversion_mode != MODE_AUTO)
                    next_q.seq = SEQ_IDLE;
                else if (q.base_cnt == 16'h0000)
                begin
                    // one start every (divider + 1) base ticks
                    if (q.div_cnt >= {12'h000, clk_div})     // RULE_10
                    begin
                        next_q.div_cnt = 16'h0000;
                        next_q.start   = 1'b1;               // RULE_08
                    end
                    else
                        next_q.div_cnt = q.div_cnt + 16'h0001;
                end
            end
            SEQ_PAUSED:
            begin
                // resume once the flag is cleared
                if (!seq_hold)
                    next_q.seq = SEQ_IDLE;                   // RULE_06
            end
        endcase

        // output data word, with fixed pattern override
        if (i_data_rd)
        begin
            if (q.regs.data_format_config[FIXED_PATTERN_BIT])
                next_q.sample = FIXED_CODE;                  // RULE_01
            else
                next_q.sample = i_conv_result;
            unique case (append_sel)                         // RULE_03
                APPEND_CHAN_ID: next_q.tag = i_conv_channel;
                APPEND_STATUS:  next_q.tag = i_conv_flags;
                default:        next_q.tag = 4'h0;
            endcase
        end
    end

    // ==========================================================
    // state register, everything clears to zero
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q.regs     <= '0;                                // RULE_13
            q.seq      <= SEQ_IDLE;
            q.base_cnt <= 16'h0000;
            q.div_cnt  <= 16'h0000;
            q.rdata    <= 8'h00;
            q.sample   <= 12'h000;
            q.tag      <= 4'h0;
            q.start    <= 1'b0;
        end
        else
            q <= next_q;
    end

    // ==========================================================
    // outputs
    always_comb
    begin
        o_reg_rdata      = q.rdata;
        o_data_word      = q.sample;
        o_data_tag       = q.tag;
        o_data_tag_valid = q.regs.data_format_config[APPEND_LSB +: 2]
                           inside {APPEND_CHAN_ID, APPEND_STATUS};
        o_conv_start     = q.start;
        // samples = 2 ** code; code 0 gives a single sample
        o_avg_samples    = 8'h01 <<
                           q.regs.averaging_config[2:0];     // RULE_04
        o_osc_low_power  =
            q.regs.operating_mode_config[OSCILLATOR_SELECT_BIT];       // RULE_09
        // config kept underneath, restored when force drops
        o_pin_gpio   = force_all ? 8'h00 :
                       q.regs.channel_function_config;       // RULE_16
        o_pin_output = force_all ? 8'h00 :
                       (q.regs.channel_function_config &
                        q.regs.digital_direction_config);    // RULE_16
        o_crc_error_flag = q.regs.crc_error;
    end

endmodule
`default_nettype wire
